// >>> core/ppx_crossbar.sv
// top of the priority pin crossbar: registers, pin cells, peripheral return path
//
// Chosen here: strobed register access.
`timescale 1ns/1ps

// How it works
// R1 - each request takes lowest free pin
// R2 - uart a fixed on pins 4 and 5
// R3 - taken or skipped pins are passed over
// R4 - two-wire bus and uarts claim pin pairs
// R5 - leftover pins stay plain port io
// R6 - slave select gets pin only in four-wire
// R7 - crossbar off: inputs only, ports 0-3 undriven
// R8 - port 4 is always plain port io
// R9 - analog pin: no pullup, driver, receiver
// R10 - input kind 1 digital, 0 analog; reset digital
// R11 - drive kind per pin; two-wire always open-drain
// R12 - open-drain pullup unless disabled or driving low
// R13 - route a bits enable the listed functions
// R14 - route b bits route timer and counter clock
// R15 - module count field routes that many modules; counts 6 and 7 route none
// R16 - latch read returns live pin level
// R17 - software skips pins used outside the crossbar
// R18 - software configures before enabling crossbar
// R19 - digital input: drive kind 0, latch 1
// R20 - skip bit 1 passes pin over; reset zero
// R21 - route c bit 0 routes uart b
// R22 - remaining priority order is a parameter
module ppx_crossbar #(
  parameter logic [ppx_pkg::NPRIO-1:0][ppx_pkg::SLOT_W-1:0] PRIO_ORDER = ppx_pkg::DEFAULT_ORDER
) (
  input  wire logic                      mclk_i,
  input  wire logic                      arst_n_i,
  input  wire logic [7:0]                reg_addr_i,
  input  wire logic [7:0]                reg_wdata_i,
  input  wire logic                      reg_wr_i,
  input  wire logic                      reg_rd_i,
  output logic      [7:0]                reg_rdata_o,
  input  wire logic [ppx_pkg::NPIN-1:0]  pin_in_i,
  output logic      [ppx_pkg::NPIN-1:0]  pin_out_o,
  output logic      [ppx_pkg::NPIN-1:0]  pin_oe_o,
  output logic      [ppx_pkg::NPIN-1:0]  pin_pullup_o,
  output logic      [ppx_pkg::NPIN-1:0]  pin_rx_en_o,
  input  wire logic                      spi_four_wire_i,
  input  wire logic [ppx_pkg::NSLOT-1:0] perif_out_i,
  input  wire logic [ppx_pkg::NSLOT-1:0] perif_drive_i,
  output logic      [ppx_pkg::NSLOT-1:0] perif_in_o
);

  localparam int NP = ppx_pkg::NPORT;

  logic [7:0]                route_a_r;
  logic [7:0]                route_b_r;
  logic [7:0]                route_c_r;
  logic [NP-1:0][7:0]        latch_r;
  logic [NP-1:0][7:0]        inkind_r;
  logic [NP-1:0][7:0]        drive_r;
  logic [NP-2:0][7:0]        skip_r;
  logic [7:0]                rdata_nxt;
  logic [ppx_pkg::NPIN-1:0]  out_nxt;
  logic [ppx_pkg::NPIN-1:0]  oe_nxt;
  logic [ppx_pkg::NPIN-1:0]  pu_nxt;
  logic [ppx_pkg::NPIN-1:0]  pin_dig;
  logic [ppx_pkg::NSLOT-1:0] perif_in_nxt;
  logic [ppx_pkg::NPIN-1:0]  taken40;
  logic [ppx_pkg::NPIN-1:0][ppx_pkg::SLOT_W-1:0] owner40;
  logic [ppx_pkg::NPIN-1:0]  latch_v;
  logic [ppx_pkg::NPIN-1:0]  inkind_v;
  logic [ppx_pkg::NPIN-1:0]  drive_v;
  logic                      xbar_en;
  logic                      pud;
  logic [NP-1:0]             hit_latch;
  logic [NP-1:0]             hit_inkind;
  logic [NP-1:0]             hit_drive;
  logic [NP-1:0]             hit_skip;
  logic [2:0]                cex_cnt;

  ppx_map_if map ();

  ppx_alloc #(
    .PRIO_ORDER (PRIO_ORDER)
  ) u_alloc (
    .map (map.alloc)
  );

  // one-hot port match of an address against a per-port offset table
  function automatic logic [NP-1:0] port_hit(input logic [7:0] a,
                                             input logic [NP-1:0][7:0] tbl);
    logic [NP-1:0] h;
    h = '0;
    for (int p = 0; p < NP; p++) begin
      h[p] = (a == tbl[p]);
    end
    return h;
  endfunction

  assign hit_latch  = port_hit(reg_addr_i, ppx_pkg::LATCH_ADDR);
  assign hit_inkind = port_hit(reg_addr_i, ppx_pkg::INKIND_ADDR);
  assign hit_drive  = port_hit(reg_addr_i, ppx_pkg::DRIVE_ADDR);
  // port 4 never takes part in allocation, so its skip entry is unmapped
  assign hit_skip   = port_hit(reg_addr_i, ppx_pkg::SKIP_ADDR) & {1'b0, {(NP-1){1'b1}}};

  assign latch_v  = latch_r;
  assign inkind_v = inkind_r;
  assign drive_v  = drive_r;
  assign xbar_en  = route_b_r[ppx_pkg::RB_XBAR_EN];
  assign pud      = route_b_r[ppx_pkg::RB_PULLUP_DIS];
  assign cex_cnt  = route_b_r[ppx_pkg::RB_CNT_HI -: 3];

  // routing registers
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      route_a_r <= ppx_pkg::ROUTE_RST;
      route_b_r <= ppx_pkg::ROUTE_RST;
      route_c_r <= ppx_pkg::ROUTE_RST;
    end else if (reg_wr_i) begin
      if (reg_addr_i == ppx_pkg::ROUTE_A_ADDR) route_a_r <= reg_wdata_i; // see R13
      if (reg_addr_i == ppx_pkg::ROUTE_B_ADDR) route_b_r <= reg_wdata_i; // see R14
      if (reg_addr_i == ppx_pkg::ROUTE_C_ADDR) begin
        route_c_r <= reg_wdata_i & ppx_pkg::RC_MASK;                   // see R21
      end
    end
  end

  // per-port latch, input kind, drive kind and skip registers
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      latch_r  <= {NP{ppx_pkg::LATCH_RST}};
      inkind_r <= {NP{ppx_pkg::INKIND_RST}};                           // see R10
      drive_r  <= {NP{ppx_pkg::DRIVE_RST}};
      skip_r   <= {(NP-1){ppx_pkg::SKIP_RST}};                         // see R20
    end else if (reg_wr_i) begin
      for (int p = 0; p < NP; p++) begin
        if (hit_latch[p])  latch_r[p]  <= reg_wdata_i;
        if (hit_inkind[p]) inkind_r[p] <= reg_wdata_i;
        if (hit_drive[p])  drive_r[p]  <= reg_wdata_i;
      end
      for (int p = 0; p < NP - 1; p++) begin
        if (hit_skip[p]) skip_r[p] <= reg_wdata_i;
      end
    end
  end

  // requests into the allocator
  always_comb begin
    map.req = '0;
    map.req[ppx_pkg::S_UTXA]   = route_a_r[ppx_pkg::RA_UART_A];        // see R2, see R4
    map.req[ppx_pkg::S_URXA]   = route_a_r[ppx_pkg::RA_UART_A];
    map.req[ppx_pkg::S_SCK]    = route_a_r[ppx_pkg::RA_SERIAL];
    map.req[ppx_pkg::S_MISO]   = route_a_r[ppx_pkg::RA_SERIAL];
    map.req[ppx_pkg::S_MOSI]   = route_a_r[ppx_pkg::RA_SERIAL];
    map.req[ppx_pkg::S_NSS]    = route_a_r[ppx_pkg::RA_SERIAL] & spi_four_wire_i; // see R6
    map.req[ppx_pkg::S_SDA]    = route_a_r[ppx_pkg::RA_TWOWIRE];       // see R4
    map.req[ppx_pkg::S_SCL]    = route_a_r[ppx_pkg::RA_TWOWIRE];
    map.req[ppx_pkg::S_CMPA_S] = route_a_r[ppx_pkg::RA_CMPA_SYNC];     // see R13
    map.req[ppx_pkg::S_CMPA_A] = route_a_r[ppx_pkg::RA_CMPA_ASYNC];
    map.req[ppx_pkg::S_CMPB_S] = route_a_r[ppx_pkg::RA_CMPB_SYNC];
    map.req[ppx_pkg::S_CMPB_A] = route_a_r[ppx_pkg::RA_CMPB_ASYNC];
    map.req[ppx_pkg::S_CLKOUT] = route_a_r[ppx_pkg::RA_CLKOUT];
    // reserved counts 6 and 7 route no module at all
    for (int k = 0; k < ppx_pkg::NCEX; k++) begin                      // see R15
      map.req[ppx_pkg::S_COUNTER_MODULE_PIN_FIRST + k] = (cex_cnt > 3'(k)) && (cex_cnt <= 3'(ppx_pkg::NCEX));
    end
    map.req[ppx_pkg::S_ECI]    = route_b_r[ppx_pkg::RB_CNT_CLK];       // see R14
    map.req[ppx_pkg::S_TMRA]   = route_b_r[ppx_pkg::RB_TIMER_A];
    map.req[ppx_pkg::S_TMRB]   = route_b_r[ppx_pkg::RB_TIMER_B];
    map.req[ppx_pkg::S_UTXB]   = route_c_r[ppx_pkg::RC_UART_B];        // see R21, see R4
    map.req[ppx_pkg::S_URXB]   = route_c_r[ppx_pkg::RC_UART_B];
  end

  assign map.skip = skip_r;
  // port 4 has no crossbar entry, so it always falls to plain io
  assign taken40  = {{(ppx_pkg::NPIN-ppx_pkg::NXPIN){1'b0}}, map.taken};          // see R8
  assign owner40  = {{((ppx_pkg::NPIN-ppx_pkg::NXPIN)*ppx_pkg::SLOT_W){1'b0}}, map.owner};

  // pin cells
  for (genvar i = 0; i < ppx_pkg::NPIN; i++) begin : g_pin
    logic xb;
    logic val;
    logic drv;
    logic od;
    logic dig;
    assign xb  = xbar_en & taken40[i];                                 // see R5, see R7
    assign val = xb ? perif_out_i[owner40[i]] : latch_v[i];
    // ports 0-3 only drive with the crossbar on; port 4 always may
    assign drv = xb ? perif_drive_i[owner40[i]] : (xbar_en || i >= ppx_pkg::NXPIN); // see R7
    assign dig = inkind_v[i];                                          // see R10
    assign od  = ~drive_v[i] | (xb & (owner40[i] == ppx_pkg::S_SDA       // see R11
                                   || owner40[i] == ppx_pkg::S_SCL));
    assign oe_nxt[i]  = dig & drv & (~od | ~val);                      // see R9
    assign out_nxt[i] = ~od & val;
    assign pu_nxt[i]  = dig & od & ~pud & ~(drv & ~val);               // see R12, see R9
  end

  // an analog pin's receiver is off and reads as zero
  assign pin_dig = pin_in_i & inkind_v;

  always_comb begin
    perif_in_nxt = '1;
    for (int i = 0; i < ppx_pkg::NXPIN; i++) begin
      if (xbar_en && map.taken[i] && map.owner[i] < 5'(ppx_pkg::NSLOT)) begin
        perif_in_nxt[map.owner[i]] = pin_dig[i];
      end
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    rdata_nxt = 8'h00;
    if (reg_addr_i == ppx_pkg::ROUTE_A_ADDR) rdata_nxt = route_a_r;
    if (reg_addr_i == ppx_pkg::ROUTE_B_ADDR) rdata_nxt = route_b_r;
    if (reg_addr_i == ppx_pkg::ROUTE_C_ADDR) rdata_nxt = route_c_r;
    for (int p = 0; p < NP; p++) begin
      if (hit_latch[p])  rdata_nxt = pin_dig[p*8 +: 8];                // see R16
      if (hit_inkind[p]) rdata_nxt = inkind_r[p];
      if (hit_drive[p])  rdata_nxt = drive_r[p];
    end
    for (int p = 0; p < NP - 1; p++) begin
      if (hit_skip[p]) rdata_nxt = skip_r[p];
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rdata_nxt;
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // all pin controls leave through flip-flops to keep the pads glitch free
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_out_o    <= '0;
      pin_oe_o     <= '0;
      pin_pullup_o <= '0;
      pin_rx_en_o  <= '0;
      perif_in_o   <= '1;
    end else begin
      pin_out_o    <= out_nxt;
      pin_oe_o     <= oe_nxt;
      pin_pullup_o <= pu_nxt;
      pin_rx_en_o  <= inkind_v;                                        // see R9
      perif_in_o   <= perif_in_nxt;
    end
  end

  // checks
  property p_xbar_off;
    @(posedge mclk_i) disable iff (!arst_n_i)
    !xbar_en |=> pin_oe_o[ppx_pkg::NXPIN-1:0] == '0;
  endproperty
  a_xbar_off: assert property (p_xbar_off) else $error("port 0-3 driven while crossbar off"); // see R7

  property p_port4_gpio;
    @(posedge mclk_i) disable iff (!arst_n_i)
    (latch_r[4][4] && drive_r[4][4] && inkind_r[4][4])
      |=> pin_oe_o[ppx_pkg::NXPIN+4] && pin_out_o[ppx_pkg::NXPIN+4];
  endproperty
  a_port4_gpio: assert property (p_port4_gpio) else $error("port 4 pin not plain io"); // see R8

  property p_analog_off;
    @(posedge mclk_i) disable iff (!arst_n_i)
    1'b1 |=> ((pin_oe_o | pin_pullup_o | pin_rx_en_o) & ~$past(inkind_v)) == '0;
  endproperty
  a_analog_off: assert property (p_analog_off) else $error("analog pin not isolated"); // see R9

  property p_uart_fixed;
    @(posedge mclk_i) disable iff (!arst_n_i)
    route_a_r[ppx_pkg::RA_UART_A] |-> map.owner[ppx_pkg::UTXA_PIN] == ppx_pkg::S_UTXA
      && map.owner[ppx_pkg::URXA_PIN] == ppx_pkg::S_URXA && map.taken[ppx_pkg::URXA_PIN]
      && map.taken[ppx_pkg::UTXA_PIN];
  endproperty
  a_uart_fixed: assert property (p_uart_fixed) else $error("uart a off its fixed pins"); // see R2

  property p_skip_free;
    @(posedge mclk_i) disable iff (!arst_n_i)
    (map.taken & map.skip & ~(32'h3 << ppx_pkg::UTXA_PIN)) == '0;
  endproperty
  a_skip_free: assert property (p_skip_free) else $error("skipped pin allocated"); // see R3

  property p_first_low;
    @(posedge mclk_i) disable iff (!arst_n_i)
    (map.req[PRIO_ORDER[0]] && map.skip[0]== 1'b0) |-> map.owner[0] == PRIO_ORDER[0];
  endproperty
  a_first_low: assert property (p_first_low) else $error("top request not on lowest pin"); // see R1

  // per-pin views of the map, so the checks below cover every crossbar pin
  logic [ppx_pkg::NXPIN-1:0] nss_at;
  logic [ppx_pkg::NXPIN-1:0] tw_at;
  for (genvar i = 0; i < ppx_pkg::NXPIN; i++) begin : g_chk
    assign nss_at[i] = map.taken[i] && map.owner[i] == ppx_pkg::S_NSS;
    assign tw_at[i]  = map.taken[i] && (map.owner[i] == ppx_pkg::S_SDA
                                        || map.owner[i] == ppx_pkg::S_SCL);
  end

  property p_nss_three;
    @(posedge mclk_i) disable iff (!arst_n_i)
    !spi_four_wire_i |-> nss_at == '0;
  endproperty
  a_nss_three: assert property (p_nss_three) else $error("slave select placed in 3-wire"); // see R6

  property p_pushpull_nopu;
    @(posedge mclk_i) disable iff (!arst_n_i)
    route_a_r[ppx_pkg::RA_TWOWIRE] == 1'b0 ##1 1'b1
      |-> (pin_pullup_o & $past(drive_v) & ~{8'h00, $past(taken40[31:0])}) == '0;
  endproperty
  a_pushpull_nopu: assert property (p_pushpull_nopu) else $error("pullup on push-pull"); // see R12

  property p_twowire_od;
    @(posedge mclk_i) disable iff (!arst_n_i)
    xbar_en |=> (pin_out_o[ppx_pkg::NXPIN-1:0] & $past(tw_at)) == '0;
  endproperty
  a_twowire_od: assert property (p_twowire_od) else $error("two-wire pin driven high"); // see R11

  property p_latch_read;
    @(posedge mclk_i) disable iff (!arst_n_i)
    (reg_rd_i && reg_addr_i == ppx_pkg::LATCH_ADDR[0]) |=> reg_rdata_o == $past(pin_dig[7:0]);
  endproperty
  a_latch_read: assert property (p_latch_read) else $error("latch read not live pin"); // see R16

  property p_route_c_rsvd;
    @(posedge mclk_i) disable iff (!arst_n_i)
    (reg_wr_i && reg_addr_i == ppx_pkg::ROUTE_C_ADDR) |=> route_c_r[7:1] == 7'h00;
  endproperty
  a_route_c_rsvd: assert property (p_route_c_rsvd) else $error("route c reserved bits set"); // see R21

endmodule // ppx_crossbar

// >>> core/ppx_pkg.sv
// shared constants for the priority pin crossbar
package ppx_pkg;

  localparam int NPIN   = 40;  // ports 0..4, eight pins each
  localparam int NXPIN  = 32;  // ports 0..3 take part in allocation
  localparam int NPORT  = 5;
  localparam int NSLOT  = 23;
  localparam int SLOT_W = 5;
  localparam int NPRIO  = 21;
  localparam int NCEX   = 5;

  // register offsets
  localparam logic [7:0] ROUTE_A_ADDR = 8'he1;
  localparam logic [7:0] ROUTE_B_ADDR = 8'he2;
  localparam logic [7:0] ROUTE_C_ADDR = 8'he3;
  localparam logic [NPORT-1:0][7:0] LATCH_ADDR  = {8'hc7, 8'hb0, 8'ha0, 8'h90, 8'h80};
  localparam logic [NPORT-1:0][7:0] INKIND_ADDR = {8'hf5, 8'hf4, 8'hf3, 8'hf2, 8'hf1};
  localparam logic [NPORT-1:0][7:0] DRIVE_ADDR  = {8'hae, 8'ha7, 8'ha6, 8'ha5, 8'ha4};
  // the port 4 entry is a hole: that port has no skip mask
  localparam logic [NPORT-1:0][7:0] SKIP_ADDR   = {8'hd7, 8'hdf, 8'hd6, 8'hd5, 8'hd4};

  // reset values
  localparam logic [7:0] ROUTE_RST  = 8'h00;
  localparam logic [7:0] LATCH_RST  = 8'hff;
  localparam logic [7:0] INKIND_RST = 8'hff;
  localparam logic [7:0] DRIVE_RST  = 8'h00;
  localparam logic [7:0] SKIP_RST   = 8'h00;

  // field positions, route a
  localparam int RA_CMPB_ASYNC = 7;
  localparam int RA_CMPB_SYNC  = 6;
  localparam int RA_CMPA_ASYNC = 5;
  localparam int RA_CMPA_SYNC  = 4;
  localparam int RA_CLKOUT     = 3;
  localparam int RA_TWOWIRE    = 2;
  localparam int RA_SERIAL     = 1;
  localparam int RA_UART_A     = 0;
  // route b
  localparam int RB_PULLUP_DIS = 7;
  localparam int RB_XBAR_EN    = 6;
  localparam int RB_TIMER_B    = 5;
  localparam int RB_TIMER_A    = 4;
  localparam int RB_CNT_CLK    = 3;
  localparam int RB_CNT_HI     = 2;
  // route c
  localparam int RC_UART_B     = 0;
  localparam logic [7:0] RC_MASK = 8'h01;

  // fixed uart a pins
  localparam int UTXA_PIN = 4;
  localparam int URXA_PIN = 5;

  // function slots
  localparam logic [SLOT_W-1:0] S_UTXA = 5'h00, S_URXA = 5'h01;
  localparam logic [SLOT_W-1:0] S_SCK = 5'h02, S_MISO = 5'h03, S_MOSI = 5'h04, S_NSS = 5'h05;
  localparam logic [SLOT_W-1:0] S_SDA = 5'h06, S_SCL = 5'h07;
  localparam logic [SLOT_W-1:0] S_CMPA_S = 5'h08, S_CMPA_A = 5'h09;
  localparam logic [SLOT_W-1:0] S_CMPB_S = 5'h0a, S_CMPB_A = 5'h0b;
  localparam logic [SLOT_W-1:0] S_CLKOUT = 5'h0c, S_COUNTER_MODULE_PIN_FIRST = 5'h0d, S_ECI = 5'h12;
  localparam logic [SLOT_W-1:0] S_TMRA = 5'h13, S_TMRB = 5'h14;
  localparam logic [SLOT_W-1:0] S_UTXB = 5'h15, S_URXB = 5'h16;

  // element 0 is the highest priority
  localparam logic [NPRIO-1:0][SLOT_W-1:0] DEFAULT_ORDER = {
    5'h16, 5'h15, 5'h14, 5'h13, 5'h12, 5'h11, 5'h10, 5'h0f, 5'h0e, 5'h0d, 5'h0c,
    5'h0b, 5'h0a, 5'h09, 5'h08, 5'h07, 5'h06, 5'h05, 5'h04, 5'h03, 5'h02};

endpackage

// >>> core/ppx_map_if.sv
// carrier between the register side and the pin allocator
`timescale 1ns/1ps
interface ppx_map_if;
  logic [ppx_pkg::NSLOT-1:0]                     req;
  logic [ppx_pkg::NXPIN-1:0]                     skip;
  logic [ppx_pkg::NXPIN-1:0]                     taken;
  logic [ppx_pkg::NXPIN-1:0][ppx_pkg::SLOT_W-1:0] owner;
  modport alloc (input req, input skip, output taken, output owner);
  modport user  (output req, output skip, input taken, input owner);
endinterface

// >>> core/ppx_alloc.sv
// priority allocator: maps requested function slots onto crossbar pins
`timescale 1ns/1ps
module ppx_alloc #(
  parameter logic [ppx_pkg::NPRIO-1:0][ppx_pkg::SLOT_W-1:0] PRIO_ORDER = ppx_pkg::DEFAULT_ORDER
) (
  ppx_map_if.alloc map
);

  logic [ppx_pkg::NXPIN-1:0] occ;
  logic                      found;

  // one pass, highest priority first; fully combinational so the map
  // follows register writes in the same cycle
  always_comb begin
    occ       = map.skip;                                    // see R3, see R20
    map.taken = '0;
    map.owner = '0;
    found     = 1'b0;
    if (map.req[ppx_pkg::S_UTXA]) begin                      // see R2
      map.taken[ppx_pkg::UTXA_PIN] = 1'b1;
      map.owner[ppx_pkg::UTXA_PIN] = ppx_pkg::S_UTXA;
      map.taken[ppx_pkg::URXA_PIN] = 1'b1;
      map.owner[ppx_pkg::URXA_PIN] = ppx_pkg::S_URXA;
      occ[ppx_pkg::UTXA_PIN]       = 1'b1;
      occ[ppx_pkg::URXA_PIN]       = 1'b1;
    end
    for (int p = 0; p < ppx_pkg::NPRIO; p++) begin           // see R22
      found = 1'b0;
      if (map.req[PRIO_ORDER[p]]) begin
        for (int i = 0; i < ppx_pkg::NXPIN; i++) begin
          if (!found && !occ[i]) begin                       // see R1, see R3
            occ[i]       = 1'b1;
            map.taken[i] = 1'b1;
            map.owner[i] = PRIO_ORDER[p];
            found        = 1'b1;
          end
        end
      end
    end
  end

endmodule // ppx_alloc

// >>> tb/ppx_pad_model.sv
// pad model: resolves each pin level from the block's drivers and an outside driver
`timescale 1ns/1ps
module ppx_pad_model (
  input  wire logic [ppx_pkg::NPIN-1:0] pin_out_i,
  input  wire logic [ppx_pkg::NPIN-1:0] pin_oe_i,
  input  wire logic [ppx_pkg::NPIN-1:0] ext_val_i,
  output logic      [ppx_pkg::NPIN-1:0] pin_level_o
);
  // outside parts drive every pin weakly, so an enabled block driver always wins
  always_comb begin
    for (int p = 0; p < ppx_pkg::NPIN; p++) begin
      pin_level_o[p] = pin_oe_i[p] ? pin_out_i[p] : ext_val_i[p];
    end
  end
endmodule // ppx_pad_model

// >>> tb/ppx_crossbar_tb_top.sv
// self-checking bench for the priority pin crossbar
`timescale 1ns/1ps
module ppx_crossbar_tb_top;
  logic        mclk_i   = 1'b0;
  logic        arst_n_i = 1'b0;
  logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata;
  logic        wr = 1'b0, rd = 1'b0, four = 1'b0;
  logic [39:0] p_in, p_out, p_oe, p_pu, p_rx, ext = 40'h93_c55a_0ff0;
  logic [22:0] f_out = 23'h0, f_drv = 23'h0, f_in;
  logic [7:0]  ra = 8'h00, rb = 8'h00, rc = 8'h00;
  logic [39:0] skip = 40'h0, ink = '1, drk = 40'h0, lat = '1;
  int          n_mismatch = 0, num_checks = 0, cyc = 0;

  ppx_crossbar ppx_crossbar_i (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .pin_in_i(p_in),
    .pin_out_o(p_out), .pin_oe_o(p_oe), .pin_pullup_o(p_pu), .pin_rx_en_o(p_rx),
    .spi_four_wire_i(four), .perif_out_i(f_out), .perif_drive_i(f_drv), .perif_in_o(f_in));
  ppx_pad_model ppx_pad_model_i (.pin_out_i(p_out), .pin_oe_i(p_oe), .ext_val_i(ext),
    .pin_level_o(p_in));

  initial begin
    forever #25 mclk_i = ~mclk_i;
  end

  // whole run needs well under a thousand cycles
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk_reg(string what, logic [7:0] exp, logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_vec(string what, logic [39:0] exp, logic [39:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // a write also updates the shadow copy that the reference below works from
  task automatic wr_reg(logic [7:0] a, logic [7:0] d);
    @(posedge mclk_i);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk_i);
    wr    <= 1'b0;
    for (int k = 0; k < 5; k++) begin
      if (a == ppx_pkg::LATCH_ADDR[k]) lat[8*k+:8] = d;
      if (a == ppx_pkg::INKIND_ADDR[k]) ink[8*k+:8] = d;
      if (a == ppx_pkg::DRIVE_ADDR[k]) drk[8*k+:8] = d;
      if (a == ppx_pkg::SKIP_ADDR[k] && k < 4) skip[8*k+:8] = d;
    end
    if (a == ppx_pkg::ROUTE_A_ADDR) ra = d;
    if (a == ppx_pkg::ROUTE_B_ADDR) rb = d;
    if (a == ppx_pkg::ROUTE_C_ADDR) rc = d & ppx_pkg::RC_MASK;
  endtask

  task automatic rd_chk(logic [7:0] a, logic [7:0] exp);
    @(posedge mclk_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk_i);
    rd   <= 1'b0;
    #1 chk_reg($sformatf("reg %h", a), exp, rdata);
  endtask

  function automatic logic want(logic [4:0] s);
    case (s)
      5'h02, 5'h03, 5'h04: return ra[1];
      5'h05: return ra[1] & four;
      5'h06, 5'h07: return ra[2];
      5'h08: return ra[4];
      5'h09: return ra[5];
      5'h0a: return ra[6];
      5'h0b: return ra[7];
      5'h0c: return ra[3];
      5'h12: return rb[3];
      5'h13: return rb[4];
      5'h14: return rb[5];
      5'h15, 5'h16: return rc[0];
      default: return (s - 5'h0d) < {2'b00, rb[2:0]} && rb[2:0] <= 3'h5;
    endcase
  endfunction

  // reference allocation and pad cell, then every pin and slot and latch read compared
  task automatic check_all();
    logic [39:0] eo, ep, er, ev, lv;
    logic [22:0] ei;
    logic [4:0]  own [32];
    logic [4:0]  s;
    logic [31:0] tk;
    logic        od, en, v;
    int          p;
    repeat (4) @(posedge mclk_i);
    #1 tk = skip[31:0];
    for (int i = 0; i < 32; i++) own[i] = 5'h1f;
    if (ra[0]) begin
      own[4] = ppx_pkg::S_UTXA;
      own[5] = ppx_pkg::S_URXA;
      tk[5:4] = 2'b11;
    end
    for (int i = 0; i < ppx_pkg::NPRIO; i++) begin
      s = ppx_pkg::DEFAULT_ORDER[i];
      if (want(s)) begin
        p = 0;
        while (p < 32 && tk[p]) p++;
        if (p < 32) begin
          own[p] = s;
          tk[p] = 1'b1;
        end
      end
    end
    for (int q = 0; q < 40; q++) begin
      s = (q < 32 && rb[6]) ? own[q] : 5'h1f;
      od = !drk[q] || s == ppx_pkg::S_SDA || s == ppx_pkg::S_SCL;
      en = (q >= 32 || rb[6]) && (s == 5'h1f || f_drv[s]);
      v = s == 5'h1f ? lat[q] : f_out[s];
      er[q] = ink[q];
      ev[q] = od ? 1'b0 : v;
      eo[q] = ink[q] && en && (!od || !v);
      ep[q] = ink[q] && od && !rb[7] && !(en && !v);
      lv[q] = eo[q] ? ev[q] : ext[q];
    end
    ei = '1;
    for (int q = 0; q < 32; q++) begin
      if (rb[6] && own[q] != 5'h1f) ei[own[q]] = lv[q] & ink[q];
    end
    chk_vec("pin_oe", eo, p_oe);
    chk_vec("pin_pullup", ep, p_pu);
    chk_vec("pin_rx_en", er, p_rx);
    chk_vec("pin_out", ev, p_out);
    chk_vec("perif_in", {17'h0, ei}, {17'h0, f_in});
    for (int k = 0; k < 5; k++) rd_chk(ppx_pkg::LATCH_ADDR[k], lv[8*k+:8] & ink[8*k+:8]);
  endtask

  task automatic t_reset();
    check_all();
    rd_chk(ppx_pkg::ROUTE_A_ADDR, 8'h00);
    rd_chk(ppx_pkg::ROUTE_B_ADDR, 8'h00);
    for (int k = 0; k < 4; k++) begin
      rd_chk(ppx_pkg::SKIP_ADDR[k], 8'h00);
      rd_chk(ppx_pkg::INKIND_ADDR[k], 8'hff);
      rd_chk(ppx_pkg::DRIVE_ADDR[k], 8'h00);
    end
    wr_reg(ppx_pkg::ROUTE_C_ADDR, 8'hff);
    rd_chk(ppx_pkg::ROUTE_C_ADDR, 8'h01);
    wr_reg(8'hd7, 8'hff);
    rd_chk(8'hd7, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_xbar_off();
    @(posedge mclk_i);
    f_drv <= '1;
    f_out <= 23'h2a_5c3a;
    for (int k = 0; k < 5; k++) wr_reg(ppx_pkg::DRIVE_ADDR[k], 8'hf0);
    wr_reg(ppx_pkg::LATCH_ADDR[0], 8'h3c);
    wr_reg(ppx_pkg::LATCH_ADDR[4], 8'h5a);
    wr_reg(ppx_pkg::ROUTE_A_ADDR, 8'hff);
    check_all();
    $display("test crossbar off done");
  endtask

  task automatic t_spi();
    wr_reg(ppx_pkg::ROUTE_C_ADDR, 8'h00);
    wr_reg(ppx_pkg::ROUTE_A_ADDR, 8'h02);
    wr_reg(ppx_pkg::ROUTE_B_ADDR, 8'h40);
    check_all();
    @(posedge mclk_i);
    four <= 1'b1;
    check_all();
    $display("test spi modes done");
  endtask

  // configuration kept in the documented order, crossbar enabled last
  task automatic t_full();
    wr_reg(ppx_pkg::ROUTE_B_ADDR, 8'h00);
    wr_reg(ppx_pkg::INKIND_ADDR[0], 8'hff);
    wr_reg(ppx_pkg::DRIVE_ADDR[0], 8'h0f);
    wr_reg(ppx_pkg::DRIVE_ADDR[1], 8'h06);
    wr_reg(ppx_pkg::SKIP_ADDR[0], 8'h0c);
    wr_reg(ppx_pkg::SKIP_ADDR[1], 8'h01);
    wr_reg(ppx_pkg::ROUTE_A_ADDR, 8'hff);
    wr_reg(ppx_pkg::ROUTE_C_ADDR, 8'h01);
    wr_reg(ppx_pkg::ROUTE_B_ADDR, 8'h3d);
    @(posedge mclk_i);
    f_drv <= 23'h2b_7f5d;
    wr_reg(ppx_pkg::ROUTE_B_ADDR, 8'h7d);
    check_all();
    for (int n = 0; n < 8; n++) begin
      wr_reg(ppx_pkg::ROUTE_B_ADDR, 8'h40 | 8'(n));
      check_all();
    end
    $display("test full allocation done");
  endtask

  task automatic t_analog();
    wr_reg(ppx_pkg::INKIND_ADDR[1], 8'h0f);
    wr_reg(ppx_pkg::SKIP_ADDR[1], 8'hf0);
    wr_reg(ppx_pkg::INKIND_ADDR[4], 8'hf0);
    wr_reg(ppx_pkg::DRIVE_ADDR[3], 8'h00);
    wr_reg(ppx_pkg::LATCH_ADDR[3], 8'hff);
    check_all();
    wr_reg(ppx_pkg::ROUTE_B_ADDR, 8'hfd);
    check_all();
    $display("test analog and pull-ups done");
  endtask

  initial begin
    repeat (5) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    t_reset();
    t_xbar_off();
    t_spi();
    t_full();
    t_analog();
    tally_and_finish();
  end
endmodule // ppx_crossbar_tb_top
